/* hdl/event_routing_unit.sv */
// What this block does
// - ones in channel_enable_set enable channels, zeros do nothing.
// - ones in channel_disable_clear disable channels, zeros do nothing.
// - ones in software_event_trigger raise a software event per channel.
// - channel_user_busy reads one while a channel or its user is busy.
// - ones in trigger_irq_mask_set set trigger mask bits.
// - ones in trigger_irq_mask_clear clear trigger mask bits.
// - trigger_irq_mask resets to zero and a one enables its interrupt.
// - trigger_irq_status resets to zero and sets on each channel event.
// - ones in trigger_irq_status_clear clear trigger status bits.
// - ones in overrun_irq_mask_set set overrun mask bits.
// - channel_status resets to zero and shows one per enabled channel.
// - ones in overrun_irq_mask_clear clear overrun mask bits, reset zero.
// - overrun status sets on an overrun and its clear register clears it.
// - software_select picks the software event, else generator_select.
`include "event_routing_params.svh"
`default_nettype none
module event_routing_unit
   import event_routing_pkg::*;
#(
   parameter int NCHAN = 32,
   parameter int NGEN = 64
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic [9:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [NGEN-1:0] GEN_EVENT,
   output logic [NCHAN-1:0] CH_EVENT,
   input wire logic [NCHAN-1:0] USER_ACK,
   input wire logic [NCHAN-1:0] USER_BUSY,
   output logic IRQ
);

   // expand byte enables into a bit mask over the write data
   function automatic word_type lane_mask(input lanes_type be);
      word_type m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return m;
   endfunction

   // set wins over clear so a same-cycle event is never lost
   function automatic word_type set_clear(input word_type old,
                                          input word_type set,
                                          input word_type clr);
      return (old & ~clr) | set;
   endfunction

   // pick one generator line; out-of-range selects give no input
   function automatic logic pick_gen(input logic [NGEN-1:0] gens,
                                     input logic [5:0] sel);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < NGEN; k++) begin
         if (sel == 6'(k)) begin
            hit = gens[k];
         end
      end
      return hit;
   endfunction

   // registers
   logic waitreq_r;
   word_type readdata_r;
   word_type chan_status_r;
   word_type trig_mask_r;
   word_type trig_status_r;
   word_type ovr_mask_r;
   word_type ovr_status_r;
   word_type pending_r;
   word_type ch_event_r;
   word_type user_busy_r;
   logic irq_r;
   mux_entry_type mux_r [0:NCHAN-1];

   // next values
   logic waitreq_nxt;
   word_type readdata_nxt;
   word_type chan_status_nxt;
   word_type trig_mask_nxt;
   word_type trig_status_nxt;
   word_type ovr_mask_nxt;
   word_type ovr_status_nxt;
   word_type pending_nxt;
   logic irq_nxt;

   // bus decode; the low two address bits are ignored
   wire byte_addr_type word_addr = {AVS_ADDRESS[9:2], 2'b00};
   wire logic wr_take = AVS_WRITE & ~waitreq_r;
   wire logic rd_load = AVS_READ & waitreq_r;
   wire word_type wdata = AVS_WRITEDATA & lane_mask(AVS_BYTEENABLE);
   wire logic hit_en = word_addr == `OFS_CHANNEL_ENABLE_SET;
   wire logic hit_dis = word_addr == `OFS_CHANNEL_DISABLE_CLEAR;
   wire logic hit_sev = word_addr == `OFS_SOFTWARE_EVENT_TRIGGER;
   wire logic hit_tset = word_addr == `OFS_TRIGGER_IRQ_MASK_SET;
   wire logic hit_tclr = word_addr == `OFS_TRIGGER_IRQ_MASK_CLEAR;
   wire logic hit_tsclr = word_addr == `OFS_TRIGGER_IRQ_STATUS_CLEAR;
   wire logic hit_oset = word_addr == `OFS_OVERRUN_IRQ_MASK_SET;
   wire logic hit_oclr = word_addr == `OFS_OVERRUN_IRQ_MASK_CLEAR;
   wire logic hit_osclr = word_addr == `OFS_OVERRUN_IRQ_STATUS_CLEAR;
   wire logic hit_mux = (word_addr >= `OFS_CHANNEL_MUX_BASE) &&
                        (word_addr <= `OFS_CHANNEL_MUX_LAST);
   wire logic [4:0] mux_idx = AVS_ADDRESS[6:2];
   // six bits so that a full 32-channel unit does not wrap to zero
   wire logic mux_live = hit_mux && ({1'b0, mux_idx} < 6'(NCHAN));

   // one-cycle write strobes, masked by byte lanes
   wire word_type en_set = (wr_take & hit_en) ? wdata : `WORD_RESET;
   wire word_type dis_clr = (wr_take & hit_dis) ? wdata : `WORD_RESET;
   wire word_type sev_hit = (wr_take & hit_sev) ? wdata : `WORD_RESET;
   wire word_type tm_set = (wr_take & hit_tset) ? wdata : `WORD_RESET;
   wire word_type tm_clr = (wr_take & hit_tclr) ? wdata : `WORD_RESET;
   wire word_type ts_clr = (wr_take & hit_tsclr) ? wdata : `WORD_RESET;
   wire word_type om_set = (wr_take & hit_oset) ? wdata : `WORD_RESET;
   wire word_type om_clr = (wr_take & hit_oclr) ? wdata : `WORD_RESET;
   wire word_type os_clr = (wr_take & hit_osclr) ? wdata : `WORD_RESET;

   // channel input selection and event qualification
   word_type raw_evt;
   word_type sw_sel;
   word_type taken_evt;
   word_type ovr_evt;
   wire word_type user_ack = word_type'(USER_ACK);
   for (genvar i = 0; i < 32; i++) begin : g_chan
      if (i < NCHAN) begin : g_live
         assign sw_sel[i] = mux_r[i].software_select;
         assign raw_evt[i] = mux_r[i].software_select ? sev_hit[i] :
            pick_gen(GEN_EVENT, mux_r[i].generator_select);
      end else begin : g_none
         assign sw_sel[i] = 1'b0;
         assign raw_evt[i] = 1'b0;
      end
   end
   // disabled channels drop their events
   assign taken_evt = raw_evt & chan_status_r;
   // a new event while the previous one is still unacknowledged
   assign ovr_evt = taken_evt & pending_r & ~user_ack;

   // busy covers the channel's own pending event and its user
   wire word_type busy_vec = pending_r | user_busy_r;

   // register state update
   always_comb begin
      chan_status_nxt = set_clear(chan_status_r, en_set, dis_clr);
      if (|dis_clr) begin
         chan_status_nxt = chan_status_r & ~dis_clr;
      end
      trig_mask_nxt = set_clear(trig_mask_r, tm_set, tm_clr);
      ovr_mask_nxt = set_clear(ovr_mask_r, om_set, om_clr);
      trig_status_nxt = set_clear(trig_status_r, taken_evt, ts_clr);
      ovr_status_nxt = set_clear(ovr_status_r, ovr_evt, os_clr);
      pending_nxt = set_clear(pending_r, taken_evt, user_ack);
   end

   // interrupt combines both status groups under their masks
   assign irq_nxt = |((trig_status_r & trig_mask_r) |
                      (ovr_status_r & ovr_mask_r));

   // one wait cycle per access keeps read data straight from a flop
   assign waitreq_nxt = ~((AVS_READ | AVS_WRITE) & waitreq_r);

   // read mux; write-only and unmapped words read zero
   always_comb begin
      readdata_nxt = `READ_ZERO;
      case (word_addr)
         `OFS_CHANNEL_STATUS: readdata_nxt = chan_status_r;
         `OFS_CHANNEL_USER_BUSY: readdata_nxt = busy_vec;
         `OFS_TRIGGER_IRQ_MASK: readdata_nxt = trig_mask_r;
         `OFS_TRIGGER_IRQ_STATUS: readdata_nxt = trig_status_r;
         `OFS_OVERRUN_IRQ_MASK: readdata_nxt = ovr_mask_r;
         `OFS_OVERRUN_IRQ_STATUS: readdata_nxt = ovr_status_r;
         default: begin
            if (mux_live) begin
               readdata_nxt[`MUX_SOFTWARE_SELECT_BIT] =
                  mux_r[mux_idx].software_select;
               readdata_nxt[`MUX_GENERATOR_SELECT_MSB:
                            `MUX_GENERATOR_SELECT_LSB] =
                  mux_r[mux_idx].generator_select;
            end
         end
      endcase
   end

   // bus answer flops
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         waitreq_r <= 1'b1;
         readdata_r <= `WORD_RESET;
      end else begin
         waitreq_r <= waitreq_nxt;
         readdata_r <= rd_load ? readdata_nxt : readdata_r;
      end
   end

   // control and status flops, all reset to zero
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         chan_status_r <= `WORD_RESET;
         trig_mask_r <= `WORD_RESET;
         trig_status_r <= `WORD_RESET;
         ovr_mask_r <= `WORD_RESET;
         ovr_status_r <= `WORD_RESET;
      end else begin
         chan_status_r <= chan_status_nxt;
         trig_mask_r <= trig_mask_nxt;
         trig_status_r <= trig_status_nxt;
         ovr_mask_r <= ovr_mask_nxt;
         ovr_status_r <= ovr_status_nxt;
      end
   end

   // event delivery to users
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         pending_r <= `WORD_RESET;
         ch_event_r <= `WORD_RESET;
         user_busy_r <= `WORD_RESET;
         irq_r <= 1'b0;
      end else begin
         pending_r <= pending_nxt;
         ch_event_r <= taken_evt;
         user_busy_r <= word_type'(USER_BUSY);
         irq_r <= irq_nxt;
      end
   end

   // channel multiplexer words honour byte lanes
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int c = 0; c < NCHAN; c++) begin
            mux_r[c] <= `MUX_RESET;
         end
      end else if (wr_take && mux_live) begin
         if (AVS_BYTEENABLE[1]) begin
            mux_r[mux_idx].software_select <=
               AVS_WRITEDATA[`MUX_SOFTWARE_SELECT_BIT];
         end
         if (AVS_BYTEENABLE[0]) begin
            mux_r[mux_idx].generator_select <=
               AVS_WRITEDATA[`MUX_GENERATOR_SELECT_MSB:
                             `MUX_GENERATOR_SELECT_LSB];
         end
      end
   end

   assign AVS_WAITREQUEST = waitreq_r;
   assign AVS_READDATA = readdata_r;
   assign CH_EVENT = ch_event_r[NCHAN-1:0];
   assign IRQ = irq_r;

   // checks
   property p_enable_sets;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_en) |=> ((chan_status_r & $past(wdata)) ==
                              $past(wdata));
   endproperty
   a_enable_sets: assert property (p_enable_sets)
      else $error("channel enable write did not set status");

   property p_disable_clears;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_dis) |=> ((chan_status_r & $past(wdata)) == 0) &&
         ((chan_status_r & ~$past(wdata)) ==
          ($past(chan_status_r) & ~$past(wdata)));
   endproperty
   a_disable_clears: assert property (p_disable_clears)
      else $error("channel disable write wrong");

   property p_sev_delivers;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_sev) |=>
         ((ch_event_r & $past(wdata & sw_sel & chan_status_r)) ==
          $past(wdata & sw_sel & chan_status_r));
   endproperty
   a_sev_delivers: assert property (p_sev_delivers)
      else $error("software event not delivered");

   property p_busy_read;
      @(posedge CLOCK) disable iff (!ARST_N)
      (rd_load && word_addr == `OFS_CHANNEL_USER_BUSY) |=>
         (AVS_READDATA == $past(busy_vec)) && !AVS_WAITREQUEST;
   endproperty
   a_busy_read: assert property (p_busy_read)
      else $error("busy read value wrong");

   property p_tmask_set;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_tset) |=> ((trig_mask_r & $past(wdata)) ==
                                $past(wdata));
   endproperty
   a_tmask_set: assert property (p_tmask_set)
      else $error("trigger mask set failed");

   property p_tmask_clear;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_tclr) |=> ((trig_mask_r & $past(wdata)) == 0);
   endproperty
   a_tmask_clear: assert property (p_tmask_clear)
      else $error("trigger mask clear failed");

   property p_tstatus_set;
      @(posedge CLOCK) disable iff (!ARST_N)
      (taken_evt != 0) |=> ((trig_status_r & $past(taken_evt)) ==
                            $past(taken_evt));
   endproperty
   a_tstatus_set: assert property (p_tstatus_set)
      else $error("trigger status missed an event");

   property p_tstatus_clear;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_tsclr) |=>
         ((trig_status_r & $past(wdata & ~taken_evt)) == 0);
   endproperty
   a_tstatus_clear: assert property (p_tstatus_clear)
      else $error("trigger status clear failed");

   property p_ovr_status;
      @(posedge CLOCK) disable iff (!ARST_N)
      (ovr_evt != 0) |=> ((ovr_status_r & $past(ovr_evt)) ==
                          $past(ovr_evt));
   endproperty
   a_ovr_status: assert property (p_ovr_status)
      else $error("overrun not recorded");

   property p_irq_level;
      @(posedge CLOCK) disable iff (!ARST_N)
      ((trig_status_r & trig_mask_r) != 0) |=> IRQ;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt missing");

   property p_wo_reads_zero;
      @(posedge CLOCK) disable iff (!ARST_N)
      (rd_load && (hit_en || hit_sev || hit_tsclr)) |=>
         (AVS_READDATA == 0);
   endproperty
   a_wo_reads_zero: assert property (p_wo_reads_zero)
      else $error("write-only register read non-zero");

   property p_omask_set;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_oset) |=> ((ovr_mask_r & $past(wdata)) ==
                                $past(wdata));
   endproperty
   a_omask_set: assert property (p_omask_set)
      else $error("overrun mask set failed");

   property p_omask_clear;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_oclr) |=> ((ovr_mask_r & $past(wdata)) == 0);
   endproperty
   a_omask_clear: assert property (p_omask_clear)
      else $error("overrun mask clear failed");

   property p_sev_blocked;
      @(posedge CLOCK) disable iff (!ARST_N)
      (wr_take && hit_sev && (GEN_EVENT == '0)) |=>
         ((ch_event_r & $past(wdata & ~sw_sel)) == 0);
   endproperty
   a_sev_blocked: assert property (p_sev_blocked)
      else $error("software event reached a generator channel");

   property p_irq_quiet;
      @(posedge CLOCK) disable iff (!ARST_N)
      (((trig_status_r & trig_mask_r) | (ovr_status_r & ovr_mask_r)) == 0)
         |=> !IRQ;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("interrupt high with nothing pending");

endmodule
`default_nettype wire

/* hdl/event_routing_params.svh */
`ifndef EVENT_ROUTING_PARAMS_SVH
`define EVENT_ROUTING_PARAMS_SVH

// byte offsets of the register map
`define OFS_CHANNEL_STATUS 10'h000
`define OFS_CHANNEL_ENABLE_SET 10'h004
`define OFS_CHANNEL_DISABLE_CLEAR 10'h008
`define OFS_SOFTWARE_EVENT_TRIGGER 10'h010
`define OFS_CHANNEL_USER_BUSY 10'h014
`define OFS_TRIGGER_IRQ_MASK_SET 10'h020
`define OFS_TRIGGER_IRQ_MASK_CLEAR 10'h024
`define OFS_TRIGGER_IRQ_MASK 10'h028
`define OFS_TRIGGER_IRQ_STATUS 10'h030
`define OFS_TRIGGER_IRQ_STATUS_CLEAR 10'h034
`define OFS_OVERRUN_IRQ_MASK_SET 10'h040
`define OFS_OVERRUN_IRQ_MASK_CLEAR 10'h044
`define OFS_OVERRUN_IRQ_MASK 10'h048
`define OFS_OVERRUN_IRQ_STATUS 10'h050
`define OFS_OVERRUN_IRQ_STATUS_CLEAR 10'h054
`define OFS_CHANNEL_MUX_BASE 10'h100
`define OFS_CHANNEL_MUX_LAST 10'h17C

// channel multiplexer word layout
`define MUX_SOFTWARE_SELECT_BIT 8
`define MUX_GENERATOR_SELECT_LSB 0
`define MUX_GENERATOR_SELECT_MSB 5

// reset values
`define WORD_RESET 32'h00000000
`define MUX_RESET 7'h00
`define READ_ZERO 32'h00000000

`endif

/* hdl/event_routing_pkg.sv */
`default_nettype none
package event_routing_pkg;
   typedef logic [31:0] word_type;
   typedef logic [3:0] lanes_type;
   typedef logic [9:0] byte_addr_type;
   // per-channel mux entry: software select above generator select
   typedef struct packed {
      logic software_select;
      logic [5:0] generator_select;
   } mux_entry_type;
endpackage
`default_nettype wire

/* verif/event_far_side.sv */
`default_nettype none
module event_far_side
   import event_routing_pkg::*;
#(
   parameter int NCHAN = 32,
   parameter int NGEN = 64
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic [NCHAN-1:0] CH_EVENT,
   input wire logic SLOW,
   output logic [NGEN-1:0] GEN_EVENT,
   output logic [NCHAN-1:0] USER_ACK,
   output logic [NCHAN-1:0] USER_BUSY,
   output logic [NCHAN-1:0] SEEN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NCHAN-1:0] pend_r;
   initial begin
      GEN_EVENT = '0;
      USER_BUSY = '0;
   end
   // one-cycle generator pulse, as a real source gives
   task automatic fire(input int g);
      @(posedge CLOCK);
      GEN_EVENT[g] <= 1'b1;
      @(posedge CLOCK);
      GEN_EVENT <= '0;
   endtask
   // busy level of the users, changed just after an edge
   task automatic busy(input logic [NCHAN-1:0] v);
      @(posedge CLOCK);
      USER_BUSY <= v;
   endtask
   // user holds each event and acks a cycle later unless stalled
   // a stall lets the next event land on a pending one
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         pend_r <= '0;
         USER_ACK <= '0;
         SEEN <= '0;
      end else begin
         pend_r <= (pend_r & ~USER_ACK) | CH_EVENT;
         USER_ACK <= SLOW ? '0 : pend_r & ~USER_ACK;
         SEEN <= SEEN | CH_EVENT;
      end
   end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`default_nettype none
module tb_top import event_routing_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam word_type ONE = 32'h00000001;
   logic clock, arst_n, avs_read, avs_write, avs_waitrequest, irq, slow;
   byte_addr_type avs_address;
   word_type avs_writedata, avs_readdata, a, b;
   lanes_type avs_byteenable;
   logic [63:0] gen_event;
   logic [31:0] ch_event, user_ack, user_busy, seen;
   word_type rdq[$];
   int n_errors, checks_done, i, j, g;
   byte_addr_type zero_at[16] = '{10'h000, 10'h014, 10'h028, 10'h030,
      10'h048, 10'h050, 10'h004, 10'h008, 10'h010, 10'h020, 10'h024,
      10'h034, 10'h040, 10'h044, 10'h054, 10'h3F0};

   event_routing_unit #(.NCHAN(32), .NGEN(64)) u_dut (.CLOCK(clock),
      .ARST_N(arst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .GEN_EVENT(gen_event),
      .CH_EVENT(ch_event), .USER_ACK(user_ack), .USER_BUSY(user_busy),
      .IRQ(irq));
   event_far_side #(.NCHAN(32), .NGEN(64)) m (.CLOCK(clock),
      .ARST_N(arst_n), .CH_EVENT(ch_event), .SLOW(slow),
      .GEN_EVENT(gen_event), .USER_ACK(user_ack), .USER_BUSY(user_busy),
      .SEEN(seen));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk(input word_type got, input word_type want,
                      input string msg);
      checks_done++;
      if (got !== want) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg,
                  got, want);
      end
   endtask
   // request held until the edge that samples waitrequest low
   task automatic bus(input logic w, input byte_addr_type ad,
                      input word_type d, input lanes_type be);
      @(posedge clock);
      avs_address <= ad;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input byte_addr_type ad, input word_type d);
      bus(1'b1, ad, d, 4'hF);
   endtask
   task automatic rd(input byte_addr_type ad, input word_type want);
      rdq.push_back(want);
      bus(1'b0, ad, 32'h00000000, 4'hF);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // read data are taken at the accepting edge against the oldest note
   always @(posedge clock) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         chk(avs_readdata, rdq.pop_front(), "read data");
      end
   end

   // watchdog: the whole run needs well under a thousand accesses
   initial begin
      #100us;
      n_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      tally_and_finish();
   end

   initial begin
      arst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 10'h000;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      slow = 1'b0;
      void'($urandom(28005));
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      foreach (zero_at[k]) rd(zero_at[k], 32'h00000000);
      $display("reset values and zero reads done");
      a = $urandom();
      b = $urandom();
      wr(10'h004, a);
      rd(10'h000, a);
      wr(10'h004, b);
      rd(10'h000, a | b);
      wr(10'h008, a);
      rd(10'h000, b & ~a);
      bus(1'b1, 10'h004, 32'hFFFFFFFF, 4'h2);
      rd(10'h000, (b & ~a) | 32'h0000FF00);
      // trigger mask, then overrun mask, 0x20 apart
      for (int k = 0; k < 2; k++) begin
         a = $urandom();
         b = $urandom();
         wr(10'h020 + 10'(32 * k), a);
         wr(10'h024 + 10'(32 * k), b);
         rd(10'h028 + 10'(32 * k), a & ~b);
         wr(10'h024 + 10'(32 * k), 32'hFFFFFFFF);
         rd(10'h028 + 10'(32 * k), 32'h00000000);
      end
      $display("enable and mask registers done");
      i = $urandom_range(31);
      j = i ^ 1;
      g = 1 + $urandom_range(62);
      wr(10'h004, 32'hFFFFFFFF);
      wr(10'h100 + 10'(4 * i), 32'h00000100);
      wr(10'h100 + 10'(4 * j), word_type'(g));
      rd(10'h100 + 10'(4 * i), 32'h00000100);
      rd(10'h100 + 10'(4 * j), word_type'(g));
      wr(10'h010, (ONE << i) | (ONE << j));
      repeat (3) @(posedge clock);
      chk(seen, ONE << i, "software event");
      rd(10'h030, ONE << i);
      m.fire(g);
      repeat (3) @(posedge clock);
      chk(seen, (ONE << i) | (ONE << j), "generator event");
      rd(10'h030, (ONE << i) | (ONE << j));
      $display("event routing done");
      chk(32'(irq), 32'h00000000, "irq masked");
      wr(10'h020, ONE << i);
      repeat (2) @(posedge clock);
      chk(32'(irq), 32'h00000001, "irq trigger");
      wr(10'h034, ONE << i);
      rd(10'h030, ONE << j);
      chk(32'(irq), 32'h00000000, "irq cleared");
      wr(10'h024, 32'hFFFFFFFF);
      $display("trigger interrupt done");
      // stalled user: second event lands on a pending one
      slow <= 1'b1;
      wr(10'h010, ONE << i);
      wr(10'h010, ONE << i);
      rd(10'h014, ONE << i);
      rd(10'h050, ONE << i);
      wr(10'h040, ONE << i);
      repeat (2) @(posedge clock);
      chk(32'(irq), 32'h00000001, "irq overrun");
      slow <= 1'b0;
      m.busy(ONE << j);
      repeat (3) @(posedge clock);
      rd(10'h014, ONE << j);
      m.busy(32'h00000000);
      wr(10'h054, ONE << i);
      rd(10'h050, 32'h00000000);
      chk(32'(irq), 32'h00000000, "irq overrun cleared");
      wr(10'h034, 32'hFFFFFFFF);
      wr(10'h008, ONE << i);
      wr(10'h010, ONE << i);
      rd(10'h030, 32'h00000000);
      rd(10'h000, ~(ONE << i));
      $display("overrun and busy done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
